/* File: design/amcfg_top.sv */
// Alarm output polarity and alarm message policy configuration with APB access
`timescale 1ns/10ps
`include "amcfg_cfg.svh"

// Operation
// - A one-bit alarm_pin_polarity is kept, 0 normally open and 1 normally closed, starting at 0.
// - A written polarity changes the alarm output only after the next reset, the old one staying in force.
// - A polarity write is stored to non-volatile memory with no separate save command.
// - During an alarm the alarm output takes the state opposite its configured normal state.
// - A polarity query returns the active value together with the saved value for the next reset.
// - alarm_message_policy defaults to 0, and at 0 no unsolicited alarm or warning message is sent.
// - At policy 1 a message is sent for each detected alarm and none for warnings.
// - At policy 2 messages are sent for every alarm and for qualifying warnings.
// - A policy write takes effect at once and is stored to non-volatile memory automatically.
// - A warning message is sent only when the warning differs from the last one reported.
module amcfg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic alarm_state_flag,
  input wire logic alarm_event,
  input wire logic warn_event,
  input wire logic [7:0] warn_code,
  output logic alarm_out,
  output logic msg_valid,
  output amcfg_pkg::amcfg_kind_t msg_kind,
  output logic [7:0] msg_code,
  input wire logic msg_ready,
  input wire logic nvm_saved_pol,
  input wire logic [1:0] nvm_saved_policy,
  output logic nvm_wr_en,
  output logic nvm_wr_addr,
  output logic [1:0] nvm_wr_data,
  input wire logic nvm_wr_done
);
  import amcfg_pkg::*;

  localparam logic [2:0] IDX_POL = 3'h0;
  localparam logic [2:0] IDX_POLICY = 3'h1;
  localparam logic [2:0] IDX_STAT = 3'h2;
  localparam logic [2:0] IDX_ISTAT = 3'h3;
  localparam logic [2:0] IDX_IMASK = 3'h4;
  localparam logic [2:0] IDX_WARN = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  amcfg_top_s_t r_ff;
  amcfg_top_s_t nxt_r;
  logic nvm_busy;
  logic nvm_done;

  // ****************************************
  // Address decode, shared by read and write
  // ****************************************
  function automatic logic [2:0] amc_dec(input logic [11:0] a);
    logic [2:0] idx;
    idx = IDX_NONE;
    case (a)
      `AMC_A_POL: idx = IDX_POL;
      `AMC_A_POLICY: idx = IDX_POLICY;
      `AMC_A_STAT: idx = IDX_STAT;
      `AMC_A_ISTAT: idx = IDX_ISTAT;
      `AMC_A_IMASK: idx = IDX_IMASK;
      `AMC_A_WARN: idx = IDX_WARN;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  // Range check on written parameter values
  function automatic logic amc_bad(input logic [2:0] idx, input logic [31:0] d);
    logic bad;
    bad = 1'b0;
    if (idx == IDX_POL) begin
      bad = (d > 32'h0000_0001);
    end else if (idx == IDX_POLICY) begin
      bad = (d > {30'h0, `AMC_MP_ALL});
    end
    return bad;
  endfunction

  // ****************************************
  // Non-volatile save sequencer
  // ****************************************
  amcfg_nvm u_nvm (
    .pclk(pclk),
    .presetn(presetn),
    .save_pol(r_ff.sv_pol),
    .save_policy(r_ff.sv_policy),
    .pol_val(r_ff.pol_sav),
    .policy_val(r_ff.policy),
    .nvm_wr_done(nvm_wr_done),
    .nvm_wr_en(nvm_wr_en),
    .nvm_wr_addr(nvm_wr_addr),
    .nvm_wr_data(nvm_wr_data),
    .busy(nvm_busy),
    .done(nvm_done)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [2:0] idx;
    logic setup;
    logic wr_go;
    logic [3:0] set;
    logic [3:0] clr;
    logic take;
    idx = amc_dec(paddr);
    setup = psel && !penable;
    wr_go = psel && penable && r_ff.pready && pwrite;
    set = 4'h0;
    clr = 4'h0;
    take = 1'b0;
    nxt_r = r_ff;
    nxt_r.sv_pol = 1'b0;
    nxt_r.sv_policy = 1'b0;

    // Storage outputs come from another macro, so they are synchronised first
    nxt_r.nv_s1 = {nvm_saved_pol, nvm_saved_policy};
    nxt_r.nv_s2 = r_ff.nv_s1;

    // Boot: wait for the synchroniser, then adopt the stored values
    unique case (r_ff.st)
      AMC_BOOT: begin
        nxt_r.boot_cnt = r_ff.boot_cnt + 2'h1;
        if (r_ff.boot_cnt == `AMC_BOOT_CYC) begin
          nxt_r.st = AMC_LOAD;
        end
      end
      AMC_LOAD: begin
        nxt_r.pol_act = r_ff.nv_s2[2];
        nxt_r.pol_sav = r_ff.nv_s2[2];
        // A corrupt stored policy falls back to the default
        if (r_ff.nv_s2[1:0] > `AMC_MP_ALL) begin
          nxt_r.policy = `AMC_RST_POLICY;
        end else begin
          nxt_r.policy = r_ff.nv_s2[1:0];
        end
        nxt_r.st = AMC_RUN;
      end
      AMC_RUN: begin
        nxt_r.st = AMC_RUN;
      end
    endcase

    // ****************************************
    // APB slave: one-cycle access phase
    // ****************************************
    nxt_r.pready = setup;
    if (setup) begin
      nxt_r.pslverr = (idx == IDX_NONE) || (pwrite && amc_bad(idx, pwdata));
      nxt_r.prdata = 32'h0;
      if (!pwrite) begin
        unique case (idx)
          IDX_POL: nxt_r.prdata = {30'h0, r_ff.pol_sav, r_ff.pol_act};
          IDX_POLICY: nxt_r.prdata = {30'h0, r_ff.policy};
          IDX_STAT: nxt_r.prdata = {29'h0, nvm_busy, r_ff.msg_valid, alarm_state_flag};
          IDX_ISTAT: nxt_r.prdata = {28'h0, r_ff.istat};
          IDX_IMASK: nxt_r.prdata = {28'h0, r_ff.imask};
          IDX_WARN: nxt_r.prdata = {24'h0, r_ff.last_wrn};
          default: nxt_r.prdata = 32'h0;
        endcase
      end
    end else if (!(psel && penable)) begin
      nxt_r.pslverr = 1'b0;
    end

    if (wr_go && r_ff.st == AMC_RUN) begin
      if (amc_bad(idx, pwdata)) begin
        set[`AMC_IRQ_REJ] = 1'b1;
      end else begin
        unique case (idx)
          IDX_POL: begin
            // Only the saved copy moves; the active one waits for reset
            nxt_r.pol_sav = pwdata[0];
            nxt_r.sv_pol = 1'b1;
          end
          IDX_POLICY: begin
            nxt_r.policy = pwdata[1:0];
            nxt_r.sv_policy = 1'b1;
          end
          IDX_ISTAT: clr = pwdata[3:0];
          IDX_IMASK: nxt_r.imask = pwdata[3:0];
          default: nxt_r.imask = r_ff.imask;
        endcase
      end
    end

    // ****************************************
    // Alarm pin
    // ****************************************
    // Level 1 means contact closed; an alarm flips the normal state
    nxt_r.alarm_out = r_ff.pol_act ^ alarm_state_flag;

    // ****************************************
    // Automatic messages
    // ****************************************
    if (alarm_event && r_ff.policy != `AMC_MP_NONE) begin
      nxt_r.alm_pend = 1'b1;
    end
    if (warn_event && r_ff.policy == `AMC_MP_ALL && warn_code != r_ff.last_wrn) begin
      nxt_r.wrn_pend = 1'b1;
      nxt_r.wrn_code = warn_code;
      nxt_r.last_wrn = warn_code;
    end
    // Policy changes act at once on anything still queued
    if (r_ff.policy == `AMC_MP_NONE) begin
      nxt_r.alm_pend = 1'b0;
    end
    if (r_ff.policy != `AMC_MP_ALL) begin
      nxt_r.wrn_pend = 1'b0;
    end

    if (r_ff.msg_valid && msg_ready) begin
      nxt_r.msg_valid = 1'b0;
      if (r_ff.msg_kind == AMC_MSG_ALARM) begin
        set[`AMC_IRQ_ALM] = 1'b1;
      end else begin
        set[`AMC_IRQ_WRN] = 1'b1;
      end
    end
    take = !r_ff.msg_valid || msg_ready;
    // Alarms go ahead of warnings; a repeat alarm in the cycle one is sent stays pending for its own message
    if (take && r_ff.alm_pend && r_ff.policy != `AMC_MP_NONE) begin
      nxt_r.msg_valid = 1'b1;
      nxt_r.msg_kind = AMC_MSG_ALARM;
      nxt_r.msg_code = 8'h00;
      nxt_r.alm_pend = alarm_event;
    end else if (take && r_ff.wrn_pend && r_ff.policy == `AMC_MP_ALL) begin
      nxt_r.msg_valid = 1'b1;
      nxt_r.msg_kind = AMC_MSG_WARN;
      nxt_r.msg_code = r_ff.wrn_code;
      nxt_r.wrn_pend = nxt_r.wrn_pend && (nxt_r.wrn_code != r_ff.wrn_code);
    end

    // ****************************************
    // Interrupts: sticky, write one to clear, set wins
    // ****************************************
    set[`AMC_IRQ_SAVE] = nvm_done;
    nxt_r.istat = (r_ff.istat & ~clr) | set;
    nxt_r.irq = |(nxt_r.istat & nxt_r.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
      r_ff.st <= AMC_BOOT;
      r_ff.pol_act <= `AMC_RST_POL;
      r_ff.pol_sav <= `AMC_RST_POL;
      r_ff.policy <= `AMC_RST_POLICY;
      r_ff.last_wrn <= `AMC_RST_WARN;
      r_ff.msg_kind <= AMC_MSG_ALARM;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // Outputs, all straight from flip-flops
  // ****************************************
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign irq = r_ff.irq;
  assign alarm_out = r_ff.alarm_out;
  assign msg_valid = r_ff.msg_valid;
  assign msg_kind = r_ff.msg_kind;
  assign msg_code = r_ff.msg_code;
endmodule

/* File: design/amcfg_cfg.svh */
// Offsets, field positions, reset values and timing counts of the alarm config block
`ifndef AMCFG_CFG_SVH
`define AMCFG_CFG_SVH
`define AMC_A_POL 12'h000
`define AMC_A_POLICY 12'h004
`define AMC_A_STAT 12'h008
`define AMC_A_ISTAT 12'h00c
`define AMC_A_IMASK 12'h010
`define AMC_A_WARN 12'h014
`define AMC_IRQ_ALM 0
`define AMC_IRQ_WRN 1
`define AMC_IRQ_REJ 2
`define AMC_IRQ_SAVE 3
`define AMC_MP_NONE 2'h0
`define AMC_MP_ALM 2'h1
`define AMC_MP_ALL 2'h2
`define AMC_NVM_POL 1'h0
`define AMC_NVM_POLICY 1'h1
`define AMC_RST_POL 1'h0
`define AMC_RST_POLICY 2'h0
`define AMC_RST_WARN 8'h00
`define AMC_BOOT_CYC 2'h2
`endif

/* File: design/amcfg_pkg.sv */
// Types shared by the alarm config block
package amcfg_pkg;
  typedef enum logic [1:0] {
    AMC_BOOT = 2'b00,
    AMC_LOAD = 2'b01,
    AMC_RUN = 2'b10
  } amcfg_st_t;

  typedef enum logic {
    AMC_MSG_ALARM = 1'b0,
    AMC_MSG_WARN = 1'b1
  } amcfg_kind_t;

  typedef struct packed {
    logic [1:0] pend;
    logic busy;
    logic wr_en;
    logic wr_addr;
    logic [1:0] wr_data;
    logic done;
  } amcfg_nvm_s_t;

  typedef struct packed {
    amcfg_st_t st;
    logic [1:0] boot_cnt;
    logic [2:0] nv_s1;
    logic [2:0] nv_s2;
    logic pol_act;
    logic pol_sav;
    logic [1:0] policy;
    logic [3:0] istat;
    logic [3:0] imask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic alarm_out;
    logic msg_valid;
    amcfg_kind_t msg_kind;
    logic [7:0] msg_code;
    logic alm_pend;
    logic wrn_pend;
    logic [7:0] wrn_code;
    logic [7:0] last_wrn;
    logic sv_pol;
    logic sv_policy;
  } amcfg_top_s_t;
endpackage

/* File: design/amcfg_nvm.sv */
// Save sequencer that writes parameters to non-volatile storage
`timescale 1ns/10ps
`include "amcfg_cfg.svh"
module amcfg_nvm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic save_pol,
  input wire logic save_policy,
  input wire logic pol_val,
  input wire logic [1:0] policy_val,
  input wire logic nvm_wr_done,
  output logic nvm_wr_en,
  output logic nvm_wr_addr,
  output logic [1:0] nvm_wr_data,
  output logic busy,
  output logic done
);
  import amcfg_pkg::*;

  amcfg_nvm_s_t r_ff;
  amcfg_nvm_s_t nxt_r;

  // ****************************************
  // Save sequencing
  // ****************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    // A request landing while its own item is being retired stays pending
    if (r_ff.wr_en && nvm_wr_done) begin
      nxt_r.wr_en = 1'b0;
      nxt_r.done = 1'b1;
    end
    if (!r_ff.wr_en && r_ff.pend != 2'b00) begin
      nxt_r.wr_en = 1'b1;
      if (r_ff.pend[0]) begin
        nxt_r.wr_addr = `AMC_NVM_POL;
        nxt_r.wr_data = {1'b0, pol_val};
        nxt_r.pend[0] = 1'b0;
      end else begin
        nxt_r.wr_addr = `AMC_NVM_POLICY;
        nxt_r.wr_data = policy_val;
        nxt_r.pend[1] = 1'b0;
      end
    end
    if (save_pol) begin
      nxt_r.pend[0] = 1'b1;
    end
    if (save_policy) begin
      nxt_r.pend[1] = 1'b1;
    end
    nxt_r.busy = nxt_r.wr_en | (nxt_r.pend != 2'b00);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign nvm_wr_en = r_ff.wr_en;
  assign nvm_wr_addr = r_ff.wr_addr;
  assign nvm_wr_data = r_ff.wr_data;
  assign busy = r_ff.busy;
  assign done = r_ff.done;
endmodule

/* File: test/amcfg_chk.sv */
// Port checker for the alarm config block
`timescale 1ns/10ps
`include "amcfg_cfg.svh"
module amcfg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alarm_state_flag,
  input wire logic alarm_event,
  input wire logic warn_event,
  input wire logic alarm_out,
  input wire logic msg_valid,
  input wire amcfg_pkg::amcfg_kind_t msg_kind,
  input wire logic [7:0] msg_code,
  input wire logic msg_ready,
  input wire logic nvm_wr_en,
  input wire logic nvm_wr_addr,
  input wire logic [1:0] nvm_wr_data,
  input wire logic nvm_wr_done,
  input wire logic [1:0] nvm_saved_policy
);
  import amcfg_pkg::*;
  // ********************
  // Policy mirror
  // ********************
  // Boot reloads from storage on the fourth edge after release; writes before that are ignored
  logic [1:0] mp_ff;
  logic [2:0] boot_ff;
  logic wacc;
  assign wacc = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mp_ff <= 2'h0;
      boot_ff <= 3'h0;
    end else if (boot_ff != 3'h4) begin
      boot_ff <= boot_ff + 3'h1;
      if (boot_ff == 3'h3) begin
        mp_ff <= (nvm_saved_policy > 2'h2) ? 2'h0 : nvm_saved_policy;
      end
    end else if (wacc && !pslverr && paddr == `AMC_A_POLICY) begin
      mp_ff <= pwdata[1:0];
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_ALM_FOLLOW: assert property ($changed(alarm_state_flag) |=> $changed(alarm_out))
    else $error("alarm output did not follow alarm");
  AST_REJECT: assert property (wacc && (paddr == `AMC_A_POL && pwdata > 32'h1 ||
    paddr == `AMC_A_POLICY && pwdata > 32'h2) |-> pslverr) else $error("bad value accepted");
  AST_QUIET: assert property ($rose(msg_valid) |-> mp_ff != 2'h0)
    else $error("message with policy zero");
  AST_WARN_POLICY: assert property ($rose(msg_valid) && msg_kind == AMC_MSG_WARN |->
    mp_ff == 2'h2 && msg_code != 8'h00) else $error("warning message not allowed");
  AST_ALARM_MSG: assert property (alarm_event && mp_ff != 2'h0 && !msg_valid && !$past(warn_event)
    |-> ##2 msg_valid && msg_kind == AMC_MSG_ALARM) else $error("alarm message late");
  AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=>
    msg_valid && $stable(msg_kind) && $stable(msg_code)) else $error("message dropped early");
  AST_NVM_HOLD: assert property (nvm_wr_en && !nvm_wr_done |=>
    nvm_wr_en && $stable(nvm_wr_addr) && $stable(nvm_wr_data)) else $error("save request dropped");
  AST_POL_SAVE: assert property (wacc && !pslverr && paddr == `AMC_A_POL |->
    ##[2:40] nvm_wr_en && nvm_wr_addr == `AMC_NVM_POL) else $error("polarity not saved");
endmodule

/* File: test/amcfg_store_mdl.sv */
// Behavioural non-volatile storage behind the save port
`timescale 1ns/10ps
module amcfg_store_mdl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire logic nvm_wr_en,
  input wire logic nvm_wr_addr,
  input wire logic [1:0] nvm_wr_data,
  output logic nvm_wr_done,
  output logic nvm_saved_pol = 1'h0,
  output logic [1:0] nvm_saved_policy = 2'h0
);
  // ********************
  // Write engine
  // ********************
  logic [3:0] cnt_ff;
  // Contents are left alone by reset, as real storage is
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      nvm_wr_done <= 1'b0;
    end else begin
      nvm_wr_done <= 1'b0;
      if (nvm_wr_en && !nvm_wr_done) begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff == lat) begin
          cnt_ff <= 4'h0;
          nvm_wr_done <= 1'b1;
          if (nvm_wr_addr)
            nvm_saved_policy <= nvm_wr_data;
          else
            nvm_saved_pol <= nvm_wr_data[0];
        end
      end
    end
  end
endmodule

/* File: test/tb.sv */
// Testbench for the alarm config block
`timescale 1ns/10ps
`include "amcfg_cfg.svh"
module tb;
  import amcfg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, alarm_state_flag, alarm_event;
  logic warn_event, alarm_out, msg_valid, msg_ready, nvm_wr_en, nvm_wr_addr, nvm_wr_done, nvm_saved_pol;
  logic [1:0] nvm_wr_data, nvm_saved_policy;
  logic [7:0] warn_code, msg_code;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] lat;
  amcfg_kind_t msg_kind;
  int failures, checks;
  amcfg_top amcfg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .alarm_state_flag, .alarm_event, .warn_event, .warn_code, .alarm_out, .msg_valid,
    .msg_kind, .msg_code, .msg_ready, .nvm_saved_pol, .nvm_saved_policy, .nvm_wr_en, .nvm_wr_addr,
    .nvm_wr_data, .nvm_wr_done);
  amcfg_store_mdl amcfg_store_mdl_i (.pclk, .presetn, .lat, .nvm_wr_en, .nvm_wr_addr, .nvm_wr_data,
    .nvm_wr_done, .nvm_saved_pol, .nvm_saved_policy);
  // ********************
  // Tasks
  // ********************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Selects the handshake signal to wait on: 0 ready, 1 message valid, 2 save done
  function automatic logic pick(input logic [1:0] k);
    unique case (k)
      2'h0: return pready;
      2'h1: return msg_valid;
      default: return nvm_wr_done;
    endcase
  endfunction
  task automatic wt(input logic [1:0] k);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wt(2'h0);
    if (!w)
      cmp(prdata, x);
    cmp(32'({pready, pslverr}), 32'({1'b1, e}));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task ev(input logic a, input logic w, input logic [7:0] c);
    alarm_event <= a;
    warn_event <= w;
    warn_code <= c;
    @(posedge pclk);
    alarm_event <= 1'b0;
    warn_event <= 1'b0;
    @(posedge pclk);
  endtask
  // Ready lags valid by a cycle so the hold is exercised
  task msg(input logic [8:0] x);
    wt(2'h1);
    cmp(32'({msg_valid, msg_kind, msg_code}), 32'({1'b1, x}));
    msg_ready <= 1'b1;
    @(posedge pclk);
    msg_ready <= 1'b0;
    @(posedge pclk);
  endtask
  task none;
    cyc(4);
    cmp(32'(msg_valid), 32'h0);
  endtask
  task saved(input logic [2:0] x);
    wt(2'h2);
    cmp(32'({nvm_wr_done, nvm_wr_en, nvm_wr_addr, nvm_wr_data}), 32'({2'h3, x}));
    cyc(2);
  endtask
  task complete_run;
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cyc(5000);
    failures++;
    complete_run;
  end
  // ********************
  // Tests
  // ********************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, alarm_state_flag} = '0;
    {alarm_event, warn_event, warn_code, msg_ready, lat} = '0;
    cyc(5);
    presetn <= 1'b1;
    cyc(6);
    apb(1'b0, `AMC_A_POL, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `AMC_A_POLICY, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
    alarm_state_flag <= 1'b1;
    cyc(2);
    cmp(32'(alarm_out), 32'h1);
    apb(1'b0, `AMC_A_STAT, 32'h0, 32'h1, 1'b0);
    alarm_state_flag <= 1'b0;
    ev(1'b1, 1'b1, 8'h05);
    none;
    apb(1'b1, `AMC_A_POL, 32'h2, 32'h0, 1'b1);
    apb(1'b1, `AMC_A_POLICY, 32'h3, 32'h0, 1'b1);
    apb(1'b0, `AMC_A_POLICY, 32'h0, 32'h0, 1'b0);
    apb(1'b0, `AMC_A_ISTAT, 32'h0, 32'h4, 1'b0);
    cmp(32'(irq), 32'h0);
    apb(1'b1, `AMC_A_IMASK, 32'h4, 32'h0, 1'b0);
    cyc(1);
    cmp(32'(irq), 32'h1);
    apb(1'b1, `AMC_A_ISTAT, 32'h4, 32'h0, 1'b0);
    cyc(1);
    cmp(32'(irq), 32'h0);
    lat <= 4'h5;
    apb(1'b1, `AMC_A_POLICY, 32'h1, 32'h0, 1'b0);
    apb(1'b0, `AMC_A_POLICY, 32'h0, 32'h1, 1'b0);
    saved(3'h5);
    ev(1'b1, 1'b0, 8'h00);
    msg(9'h000);
    ev(1'b0, 1'b1, 8'h05);
    none;
    lat <= 4'h0;
    apb(1'b1, `AMC_A_POLICY, 32'h2, 32'h0, 1'b0);
    saved(3'h6);
    ev(1'b0, 1'b1, 8'h05);
    msg(9'h105);
    ev(1'b0, 1'b1, 8'h05);
    none;
    ev(1'b1, 1'b1, 8'h07);
    msg(9'h000);
    msg(9'h107);
    apb(1'b0, `AMC_A_ISTAT, 32'h0, 32'hb, 1'b0);
    apb(1'b0, `AMC_A_WARN, 32'h0, 32'h7, 1'b0);
    apb(1'b1, `AMC_A_POL, 32'h1, 32'h0, 1'b0);
    apb(1'b0, `AMC_A_POL, 32'h0, 32'h2, 1'b0);
    saved(3'h1);
    cmp(32'(alarm_out), 32'h0);
    presetn <= 1'b0;
    cyc(5);
    presetn <= 1'b1;
    cyc(6);
    apb(1'b0, `AMC_A_POL, 32'h0, 32'h3, 1'b0);
    apb(1'b0, `AMC_A_POLICY, 32'h0, 32'h2, 1'b0);
    cmp(32'(alarm_out), 32'h1);
    alarm_state_flag <= 1'b1;
    cyc(2);
    cmp(32'(alarm_out), 32'h0);
    complete_run;
  end
endmodule
bind amcfg_top amcfg_chk amcfg_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .alarm_state_flag, .alarm_event, .warn_event, .alarm_out, .msg_valid, .msg_kind, .msg_code,
  .msg_ready, .nvm_wr_en, .nvm_wr_addr, .nvm_wr_data, .nvm_wr_done, .nvm_saved_policy);
